// file: dtc_pkg.sv
/*
 Shared constants for the dual timer/counter core: register addresses,
 field positions, reset values, mode codes and machine-cycle phases.
 Assumes an 8051-style special-function-register bus with 8-bit addresses.
*/
package dtc_pkg;

	// Register addresses on the special-function-register bus
	localparam logic [7:0] ADDR_TIMER_CONTROL = 8'h88;
	localparam logic [7:0] ADDR_TIMER_MODE    = 8'h89;
	localparam logic [7:0] ADDR_T0_LOW        = 8'h8a;
	localparam logic [7:0] ADDR_T1_LOW        = 8'h8b;
	localparam logic [7:0] ADDR_T0_HIGH       = 8'h8c;
	localparam logic [7:0] ADDR_T1_HIGH       = 8'h8d;

	// Reset values
	localparam logic [7:0] TIMER_CONTROL_RESET = 8'h00;
	localparam logic [7:0] TIMER_MODE_RESET    = 8'h00;
	localparam logic [7:0] COUNT_RESET         = 8'h00;
	localparam logic [7:0] UNMAPPED_READ       = 8'h00;

	// Control register fields
	localparam int TCTL_OVF_ONE  = 7;
	localparam int TCTL_RUN_ONE  = 6;
	localparam int TCTL_OVF_ZERO = 5;
	localparam int TCTL_RUN_ZERO = 4;

	// Mode register fields, per nibble (timer 1 in the upper one)
	localparam int TIMER_MODE_NIBBLE  = 4;
	localparam int TIMER_MODE_GATE    = 3;
	localparam int TIMER_MODE_CSEL    = 2;
	localparam int TIMER_MODE_MODE_LO = 0;

	// Mode field codes
	localparam logic [1:0] MODE_PRESCALED = 2'h0;
	localparam logic [1:0] MODE_CASCADED  = 2'h1;
	localparam logic [1:0] MODE_RELOAD    = 2'h2;
	localparam logic [1:0] MODE_SPLIT     = 2'h3;

	// Machine cycle: 12 core clocks, phase index = (state-1)*2 + (phase-1)
	localparam int         MC_CLOCKS    = 12;
	localparam logic [3:0] PHASE_LAST   = 4'(MC_CLOCKS - 1);
	localparam logic [3:0] SAMPLE_PHASE = 4'h9;
	localparam logic [3:0] UPDATE_PHASE = 4'h4;

	localparam logic [4:0] PRESCALE_TOP = 5'h1f;
	localparam logic [7:0] BYTE_TOP     = 8'hff;

endpackage : dtc_pkg

// file: dtc_edge_tick.sv
/*
 Count-tick generator for one timer unit: machine-cycle tick in timer
 function, sampled falling-edge tick in counter function.
 Assumes a shared machine-cycle phase counter and a synchronous count pin.
*/
`timescale 1ns/100ps
module dtc_edge_tick
	import dtc_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       rst,
	input  wire logic [3:0] phase,
	input  wire logic       count_pin,
	input  wire logic       count_select,
	input  wire logic       count_enable,
	output logic            tick
);

	logic sample_reg;
	logic fall_pend_reg;

	// Pin sampled once per machine cycle; a high then low sample is an edge
	always_ff @(posedge clock) begin
		if (rst) begin
			sample_reg    <= 1'b0;
			fall_pend_reg <= 1'b0;
		end else if (phase == SAMPLE_PHASE) begin
			sample_reg    <= count_pin;
			fall_pend_reg <= sample_reg & ~count_pin;
		end else if (phase == UPDATE_PHASE) begin
			fall_pend_reg <= 1'b0; // Edge used or dropped in the next cycle
		end
	end

	// Both sources land at the update phase; edges thus take two cycles
	always_comb begin
		tick = 1'b0;
		if (phase == UPDATE_PHASE && count_enable)
			tick = count_select ? fall_pend_reg : 1'b1;
	end

endmodule : dtc_edge_tick

// file: dtc_timer_core.sv
/*
 Two 16-bit timer/counters with mode and control registers on the
 special-function-register bus, byte and bit writes, registered read data.
 Assumes count and gate pins are synchronous to clock and that the
 interrupt logic pulses an acknowledge when it vectors to a timer routine.
*/
`timescale 1ns/100ps
module dtc_timer_core
	import dtc_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       rst,
	input  wire logic [7:0] sfr_addr,
	input  wire logic       sfr_wr,
	input  wire logic [7:0] sfr_wdata,
	input  wire logic       sfr_bit_wr,
	input  wire logic [2:0] sfr_bit_sel,
	input  wire logic       sfr_bit_data,
	output logic      [7:0] sfr_rdata,
	input  wire logic       vector_ack_zero,
	input  wire logic       vector_ack_one,
	input  wire logic       count_pin_zero,
	input  wire logic       count_pin_one,
	input  wire logic       gate_pin_zero,
	input  wire logic       gate_pin_one,
	output logic            overflow_flag_timer_zero,
	output logic            overflow_flag_timer_one
);

	logic [7:0] timer_mode_reg;
	logic [7:0] timer_control_reg;
	logic [7:0] timer_control_next;
	logic [7:0] sfr_rdata_reg;
	logic [3:0] phase_reg;
	logic [7:0] count_low_byte_reg  [2];
	logic [7:0] count_high_byte_reg [2];
	logic [1:0] tick_w;
	logic [1:0] ovf_w;
	logic [1:0] en_w;
	logic [1:0] count_pin_w;
	logic [1:0] gate_pin_w;
	logic       split_w;
	logic       high_tick_w;
	logic       high_ovf_w;

	assign count_pin_w = {count_pin_one, count_pin_zero};
	assign gate_pin_w  = {gate_pin_one, gate_pin_zero};
	assign split_w     = timer_mode_reg[TIMER_MODE_MODE_LO +: 2] == MODE_SPLIT;

	// Machine-cycle phase shared by both units
	always_ff @(posedge clock) begin
		if (rst || phase_reg == PHASE_LAST)
			phase_reg <= 4'h0;
		else
			phase_reg <= phase_reg + 4'h1;
	end

	// Split mode: timer zero high byte counts cycles under timer one run bit
	assign high_tick_w = split_w && phase_reg == UPDATE_PHASE
		&& timer_control_reg[TCTL_RUN_ONE];
	assign high_ovf_w  = high_tick_w && count_high_byte_reg[0] == BYTE_TOP;

	for (genvar i = 0; i < 2; i++) begin : g_tmr
		localparam int NB      = i * TIMER_MODE_NIBBLE;
		localparam int RUN_POS = (i == 0) ? TCTL_RUN_ZERO : TCTL_RUN_ONE;
		localparam logic [7:0] LOW_ADDR  = (i == 0) ? ADDR_T0_LOW : ADDR_T1_LOW;
		localparam logic [7:0] HIGH_ADDR = (i == 0) ? ADDR_T0_HIGH : ADDR_T1_HIGH;

		logic [1:0] mode;
		logic [7:0] low_next;
		logic [7:0] high_next;
		logic       ovf;
		logic       stopped;

		assign mode    = timer_mode_reg[NB + TIMER_MODE_MODE_LO +: 2];
		assign stopped = (i == 1) && mode == MODE_SPLIT;

		// Run bit gates everything; gate bit adds the pin condition
		assign en_w[i] = timer_control_reg[RUN_POS]
			& (~timer_mode_reg[NB + TIMER_MODE_GATE] | gate_pin_w[i]);

		dtc_edge_tick u_tick (
			.clock        (clock),
			.rst          (rst),
			.phase        (phase_reg),
			.count_pin    (count_pin_w[i]),
			.count_select (timer_mode_reg[NB + TIMER_MODE_CSEL]),
			.count_enable (en_w[i]),
			.tick         (tick_w[i])
		);

		// Next count per mode; software writes win over counting
		always_comb begin
			low_next  = count_low_byte_reg[i];
			high_next = count_high_byte_reg[i];
			ovf       = 1'b0;
			if (tick_w[i] && !stopped) begin
				case (mode)
					MODE_PRESCALED: begin
						low_next[4:0] = count_low_byte_reg[i][4:0] + 5'h01;
						if (count_low_byte_reg[i][4:0] == PRESCALE_TOP) begin
							high_next = count_high_byte_reg[i] + 8'h01;
							ovf       = count_high_byte_reg[i] == BYTE_TOP;
						end
					end
					MODE_CASCADED: begin
						{high_next, low_next} = {count_high_byte_reg[i],
							count_low_byte_reg[i]} + 16'h0001;
						ovf = {count_high_byte_reg[i], count_low_byte_reg[i]}
							== {BYTE_TOP, BYTE_TOP};
					end
					MODE_RELOAD: begin
						ovf = count_low_byte_reg[i] == BYTE_TOP;
						low_next = ovf ? count_high_byte_reg[i]
							: count_low_byte_reg[i] + 8'h01;
					end
					default: begin
						low_next = count_low_byte_reg[i] + 8'h01;
						ovf      = count_low_byte_reg[i] == BYTE_TOP;
					end
				endcase
			end
			if (i == 0 && high_tick_w)
				high_next = count_high_byte_reg[i] + 8'h01;
			if (sfr_wr && sfr_addr == LOW_ADDR)
				low_next = sfr_wdata;
			if (sfr_wr && sfr_addr == HIGH_ADDR)
				high_next = sfr_wdata;
		end

		assign ovf_w[i] = ovf;

		// Count bytes; the run bit never clears them
		always_ff @(posedge clock) begin
			if (rst) begin
				count_low_byte_reg[i]  <= COUNT_RESET;
				count_high_byte_reg[i] <= COUNT_RESET;
			end else begin
				count_low_byte_reg[i]  <= low_next;
				count_high_byte_reg[i] <= high_next;
			end
		end
	end

	// Mode register: byte writes only, no bit access
	always_ff @(posedge clock) begin
		if (rst)
			timer_mode_reg <= TIMER_MODE_RESET;
		else if (sfr_wr && sfr_addr == ADDR_TIMER_MODE)
			timer_mode_reg <= sfr_wdata;
	end

	// Control: byte write, bit write, vector clear, then hardware set wins
	always_comb begin
		timer_control_next = timer_control_reg;
		if (sfr_wr && sfr_addr == ADDR_TIMER_CONTROL)
			timer_control_next = sfr_wdata;
		if (sfr_bit_wr)
			timer_control_next[sfr_bit_sel] = sfr_bit_data;
		if (vector_ack_zero)
			timer_control_next[TCTL_OVF_ZERO] = 1'b0;
		if (vector_ack_one)
			timer_control_next[TCTL_OVF_ONE] = 1'b0;
		if (ovf_w[0])
			timer_control_next[TCTL_OVF_ZERO] = 1'b1;
		// In split mode the timer zero high byte owns the timer one flag
		if (split_w ? high_ovf_w : ovf_w[1])
			timer_control_next[TCTL_OVF_ONE] = 1'b1;
	end

	always_ff @(posedge clock) begin
		if (rst)
			timer_control_reg <= TIMER_CONTROL_RESET;
		else
			timer_control_reg <= timer_control_next;
	end

	// Read data registered every cycle from the current address
	always_ff @(posedge clock) begin
		if (rst)
			sfr_rdata_reg <= UNMAPPED_READ;
		else begin
			case (sfr_addr)
				ADDR_TIMER_CONTROL: sfr_rdata_reg <= timer_control_reg;
				ADDR_TIMER_MODE:    sfr_rdata_reg <= timer_mode_reg;
				ADDR_T0_LOW:        sfr_rdata_reg <= count_low_byte_reg[0];
				ADDR_T1_LOW:        sfr_rdata_reg <= count_low_byte_reg[1];
				ADDR_T0_HIGH:       sfr_rdata_reg <= count_high_byte_reg[0];
				ADDR_T1_HIGH:       sfr_rdata_reg <= count_high_byte_reg[1];
				default:            sfr_rdata_reg <= UNMAPPED_READ;
			endcase
		end
	end

	assign sfr_rdata                = sfr_rdata_reg;
	assign overflow_flag_timer_zero = timer_control_reg[TCTL_OVF_ZERO];
	assign overflow_flag_timer_one  = timer_control_reg[TCTL_OVF_ONE];

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	sequence s_fall_zero;
		phase_reg == SAMPLE_PHASE && count_pin_zero
			##12 !count_pin_zero;
	endsequence

	sequence s_counting_zero;
		(timer_mode_reg[TIMER_MODE_CSEL] && en_w[0])[*7];
	endsequence

	a_edge_to_tick: assert property (
		s_fall_zero ##1 s_counting_zero |-> tick_w[0])
		else $error("falling edge did not count at the update phase");

	a_tick_only_update: assert property (
		tick_w[0] |-> phase_reg == UPDATE_PHASE && $past(phase_reg, 12) == UPDATE_PHASE)
		else $error("tick outside the update phase");

	a_gate_blocks_count: assert property (
		timer_mode_reg[TIMER_MODE_GATE] && !gate_pin_zero |-> !tick_w[0])
		else $error("gated timer counted with gate pin low");

	a_cascade_inc: assert property (
		tick_w[0] && timer_mode_reg[1:0] == MODE_CASCADED && !sfr_wr
			|=> {count_high_byte_reg[0], count_low_byte_reg[0]}
			== $past({count_high_byte_reg[0], count_low_byte_reg[0]}) + 16'h0001)
		else $error("16-bit count did not advance by one");

	a_prescale_carry: assert property (
		tick_w[0] && timer_mode_reg[1:0] == MODE_PRESCALED && !sfr_wr
			&& count_low_byte_reg[0][4:0] == PRESCALE_TOP
			|=> count_high_byte_reg[0] == $past(count_high_byte_reg[0]) + 8'h01
			&& count_low_byte_reg[0][4:0] == 5'h00)
		else $error("prescaler wrap did not carry into the high byte");

	a_reload_copy: assert property (
		tick_w[0] && timer_mode_reg[1:0] == MODE_RELOAD && !sfr_wr
			&& count_low_byte_reg[0] == BYTE_TOP
			|=> count_low_byte_reg[0] == $past(count_high_byte_reg[0])
			&& $stable(count_high_byte_reg[0]) && overflow_flag_timer_zero)
		else $error("reload wrong or flag not set");

	a_stop_hold: assert property (
		timer_mode_reg[5:4] == MODE_SPLIT && !sfr_wr
			|=> $stable(count_low_byte_reg[1]) && $stable(count_high_byte_reg[1]))
		else $error("timer one moved while stopped");

	a_flag_vector_clear: assert property (
		overflow_flag_timer_zero && vector_ack_zero && !ovf_w[0]
			&& !sfr_bit_wr && !sfr_wr |=> !overflow_flag_timer_zero)
		else $error("overflow flag not cleared on vector");

	a_split_flag_one: assert property (
		high_ovf_w |=> overflow_flag_timer_one && count_high_byte_reg[0] == 8'h00)
		else $error("split high byte overflow lost");

	a_write_loads: assert property (
		sfr_wr && sfr_addr == ADDR_T0_HIGH |=> count_high_byte_reg[0] == $past(sfr_wdata))
		else $error("high byte write not loaded");

	// Run bit low must silence the unit whatever the source or gate
	a_run_stops_tick: assert property (
		!timer_control_reg[TCTL_RUN_ZERO] |-> !tick_w[0])
		else $error("timer zero ticked with run bit clear");

	// Enabled timer function must tick at every update phase
	a_cycle_tick: assert property (
		!timer_mode_reg[TIMER_MODE_CSEL] && en_w[0] && phase_reg == UPDATE_PHASE |-> tick_w[0])
		else $error("machine-cycle tick missing at update phase");

	// Split high byte advances once per machine cycle under run one
	a_split_high_step: assert property (
		split_w && phase_reg == UPDATE_PHASE && timer_control_reg[TCTL_RUN_ONE]
			&& !sfr_wr
			|=> count_high_byte_reg[0] == $past(count_high_byte_reg[0]) + 8'h01)
		else $error("split high byte did not advance");

	// Timer one rollover outside split mode owns its own flag
	a_flag_one_set: assert property (
		ovf_w[1] && !split_w |=> overflow_flag_timer_one)
		else $error("timer one overflow flag not set");

	// Gated timer one stays still while its gate pin is low
	a_gate_blocks_one: assert property (
		timer_mode_reg[TIMER_MODE_NIBBLE + TIMER_MODE_GATE] && !gate_pin_one |-> !tick_w[1])
		else $error("gated timer one counted with gate pin low");

endmodule : dtc_timer_core

// file: dtc_pins_model.sv
/*
 Far-side model of the timer pins: count-pin bursts of falling edges and
 gate-pin levels on request from the bench.
 Assumes the bench holds pin_sel, pulses and half_len while busy is high.
*/
`timescale 1ns/100ps
module dtc_pins_model (
	input  wire logic       clock,
	input  wire logic       go,
	input  wire logic       pin_sel,
	input  wire logic [3:0] pulses,
	input  wire logic [4:0] half_len,
	input  wire logic [1:0] gate_req,
	output logic            count_pin_zero,
	output logic            count_pin_one,
	output logic            gate_pin_zero,
	output logic            gate_pin_one,
	output logic            busy
);
	int len;

	// Gate levels follow the request one edge later, like a slow source
	always @(posedge clock) begin
		gate_pin_zero <= gate_req[0];
		gate_pin_one  <= gate_req[1];
	end

	// Count pins idle high; bursts never hold a level under one machine cycle
	initial begin
		count_pin_zero = 1'b1;
		count_pin_one  = 1'b1;
		busy           = 1'b0;
		forever begin
			@(posedge clock);
			if (go) begin
				busy <= 1'b1;
				len = (half_len < 5'h0c) ? 12 : int'(half_len);
				repeat (pulses) begin
					if (pin_sel) count_pin_one <= 1'b0;
					else count_pin_zero <= 1'b0;
					repeat (len) @(posedge clock);
					if (pin_sel) count_pin_one <= 1'b1;
					else count_pin_zero <= 1'b1;
					repeat (len) @(posedge clock);
				end
				busy <= 1'b0;
			end
		end
	end
endmodule : dtc_pins_model

// file: dual_timer_counter_core_tb.sv
/*
 Self-checking bench for the dual timer/counter core: registers, all modes,
 gating, pin edge counting, flags and their vectoring clear.
 Assumes dtc_pins_model drives the count and gate pins.
*/
`timescale 1ns/100ps
module dual_timer_counter_core_tb;
	import dtc_pkg::*;
	logic       clock = 1'b0;
	logic       rst = 1'b1;
	logic [7:0] sfr_addr = 8'h00;
	logic [7:0] sfr_wdata = 8'h00;
	logic [7:0] sfr_rdata;
	logic       sfr_wr = 1'b0;
	logic       sfr_bit_wr = 1'b0;
	logic [2:0] sfr_bit_sel = 3'h0;
	logic       sfr_bit_data = 1'b0;
	logic [1:0] vack = 2'h0;
	logic [1:0] greq = 2'h0;
	logic       go = 1'b0;
	logic       psel = 1'b0;
	logic [3:0] pulses = 4'h0;
	logic [4:0] hlen = 5'h0c;
	logic       cp0, cp1, gp0, gp1, of0, of1, busy;
	int         err_total = 0;
	int         checked = 0;

	always #10 clock = ~clock;

	dtc_timer_core uut (.clock(clock), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
		.sfr_wdata(sfr_wdata), .sfr_bit_wr(sfr_bit_wr), .sfr_bit_sel(sfr_bit_sel),
		.sfr_bit_data(sfr_bit_data), .sfr_rdata(sfr_rdata), .vector_ack_zero(vack[0]),
		.vector_ack_one(vack[1]), .count_pin_zero(cp0), .count_pin_one(cp1),
		.gate_pin_zero(gp0), .gate_pin_one(gp1), .overflow_flag_timer_zero(of0),
		.overflow_flag_timer_one(of1));

	dtc_pins_model pins (.clock(clock), .go(go), .pin_sel(psel), .pulses(pulses),
		.half_len(hlen), .gate_req(greq), .count_pin_zero(cp0), .count_pin_one(cp1),
		.gate_pin_zero(gp0), .gate_pin_one(gp1), .busy(busy));

	// Verdict in one place for the main sequence and the watchdog
	task automatic conclude();
		if (err_total == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : conclude

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk8

	task automatic chk1(input logic got, input logic exp);
		chk8({7'h00, got}, {7'h00, exp});
	endtask : chk1

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		sfr_addr  <= a;
		sfr_wdata <= d;
		sfr_wr    <= 1'b1;
		@(posedge clock);
		sfr_wr <= 1'b0;
	endtask : wr

	task automatic bwr(input logic [2:0] s, input logic d);
		@(posedge clock);
		sfr_bit_sel  <= s;
		sfr_bit_data <= d;
		sfr_bit_wr   <= 1'b1;
		@(posedge clock);
		sfr_bit_wr <= 1'b0;
	endtask : bwr

	// Read data is registered, so it settles one edge after the address
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock);
		sfr_addr <= a;
		@(posedge clock);
		@(posedge clock);
		#1 d = sfr_rdata;
	endtask : rd

	// Run bit held for exactly c edges, so c/12 machine-cycle ticks land
	task automatic run_for(input logic [2:0] s, input int c);
		bwr(s, 1'b1);
		repeat (c - 2) @(posedge clock);
		bwr(s, 1'b0);
	endtask : run_for

	// Reference count after n ticks: {flag, high, low}
	function automatic logic [16:0] adv(input logic [1:0] md, input logic [7:0] lo,
		input logic [7:0] hi, input int n);
		logic f;
		f = 1'b0;
		repeat (n) begin
			case (md)
				2'h0: begin
					lo[4:0] = lo[4:0] + 5'h01;
					if (lo[4:0] == 5'h00) begin
						hi = hi + 8'h01;
						f |= (hi == 8'h00);
					end
				end
				2'h1: begin
					{hi, lo} = {hi, lo} + 16'h0001;
					f |= ({hi, lo} == 16'h0000);
				end
				2'h2: begin
					lo = lo + 8'h01;
					if (lo == 8'h00) begin
						lo = hi;
						f = 1'b1;
					end
				end
				default: begin
					lo = lo + 8'h01;
					f |= (lo == 8'h00);
				end
			endcase
		end
		return {f, hi, lo};
	endfunction : adv

	// Watchdog sized well above the longest sequence
	initial begin
		repeat (40000) @(posedge clock);
		err_total++;
		conclude();
	end

	initial begin
		int          t, m, g, n;
		logic [7:0]  v, lo, hi;
		logic [16:0] e;
		void'($urandom(34063));
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		rd(ADDR_TIMER_CONTROL, v);
		chk8(v, TIMER_CONTROL_RESET);
		rd(ADDR_TIMER_MODE, v);
		chk8(v, TIMER_MODE_RESET);
		rd(8'h90, v);
		chk8(v, UNMAPPED_READ);
		lo = 8'($urandom);
		wr(ADDR_TIMER_MODE, lo);
		rd(ADDR_TIMER_MODE, v);
		chk8(v, lo);
		lo = 8'($urandom) & 8'h0f;
		wr(ADDR_TIMER_CONTROL, lo);
		rd(ADDR_TIMER_CONTROL, v);
		chk8(v, lo);
		// Every mode on both timers, gated and ungated, near overflow
		for (t = 0; t < 2; t++) for (m = 0; m < 4; m++) for (g = 0; g < 2; g++) begin
			lo = 8'hf0 | 8'($urandom % 16);
			hi = (m == 2) ? 8'($urandom) : 8'hff;
			n = 8 + $urandom % 32;
			greq <= 2'($urandom);
			wr(ADDR_TIMER_CONTROL, 8'h00);
			wr(ADDR_TIMER_MODE, 8'({g[0], 1'b0, m[1:0]}) << (4 * t));
			wr(ADDR_T0_LOW + 8'(t), lo);
			wr(ADDR_T0_HIGH + 8'(t), hi);
			run_for(3'(4 + 2 * t), 12 * n);
			e = adv(2'(m), lo, hi, ((t == 1 && m == 3) || (g == 1 && !greq[t])) ? 0 : n);
			rd(ADDR_T0_LOW + 8'(t), v);
			chk8(v, e[7:0]);
			rd(ADDR_T0_HIGH + 8'(t), v);
			chk8(v, e[15:8]);
			rd(ADDR_TIMER_CONTROL, v);
			chk1(v[5 + 2 * t], e[16]);
			chk1((t == 1) ? of1 : of0, e[16]);
			@(posedge clock);
			vack[t] <= 1'b1;
			@(posedge clock);
			vack[t] <= 1'b0;
			#1 chk1((t == 1) ? of1 : of0, 1'b0);
		end
		// Split mode: high byte of timer zero runs on timer one's run bit
		hi = 8'hf8 | 8'($urandom % 8);
		n = 4 + $urandom % 12;
		wr(ADDR_TIMER_CONTROL, 8'h00);
		wr(ADDR_TIMER_MODE, 8'h33);
		wr(ADDR_T0_HIGH, hi);
		run_for(3'h6, 12 * n);
		e = adv(2'h3, hi, 8'h00, n);
		rd(ADDR_T0_HIGH, v);
		chk8(v, e[7:0]);
		chk1(of1, e[16]);
		// Pin edge counting at and below the fastest legal rate
		for (t = 0; t < 2; t++) begin
			lo = 8'($urandom);
			n = 1 + $urandom % 10;
			wr(ADDR_TIMER_CONTROL, 8'h00);
			wr(ADDR_TIMER_MODE, 8'h05 << (4 * t));
			wr(ADDR_T0_LOW + 8'(t), lo);
			bwr(3'(4 + 2 * t), 1'b1);
			@(posedge clock);
			psel   <= t[0];
			pulses <= 4'(n);
			hlen   <= (t == 0) ? 5'h0c : 5'(12 + $urandom % 6);
			go     <= 1'b1;
			@(posedge clock);
			go <= 1'b0;
			for (g = 0; g < 600 && (busy !== 1'b0 || g == 0); g++) @(posedge clock);
			repeat (30) @(posedge clock);
			bwr(3'(4 + 2 * t), 1'b0);
			rd(ADDR_T0_LOW + 8'(t), v);
			chk8(v, lo + 8'(n));
		end
		conclude();
	end
endmodule : dual_timer_counter_core_tb
